/* File: hdl/pcsr_pkg.sv */
// Constants, field positions and types shared by the PHY control/status register block.
// Assumes a single 40 MHz core clock and a management link sampled by that clock.
package pcsr_pkg;

  localparam int CLK_PERIOD_PS = 25000;
  // Collision test bounds in bit times, and the 100 Mb/s bit time
  localparam int COL_ASSERT_BITS = 512;
  localparam int COL_RELEASE_BITS = 4;
  localparam int BIT_TIME_PS = 10000;
  localparam int COL_ASSERT_CYCLES_RAW = (COL_ASSERT_BITS * BIT_TIME_PS) / CLK_PERIOD_PS;
  localparam int COL_ASSERT_CYCLES = (COL_ASSERT_CYCLES_RAW < 1) ? 1 : COL_ASSERT_CYCLES_RAW;
  localparam int COL_RELEASE_CYCLES_RAW = (COL_RELEASE_BITS * BIT_TIME_PS) / CLK_PERIOD_PS;
  localparam int COL_RELEASE_CYCLES = (COL_RELEASE_CYCLES_RAW < 1) ? 1 : COL_RELEASE_CYCLES_RAW;
  // Synchroniser depth seen by the collision path plus its output flop
  localparam int COL_PATH_CYCLES = 3;

  // Management frame layout
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [4:0] HDR_BITS = 5'h0D;
  localparam logic [4:0] TA_BITS = 5'h02;
  localparam logic [4:0] DATA_BITS = 5'h10;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  // Register addresses
  localparam logic [4:0] ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h01;
  localparam logic [4:0] ADDR_EXT_CONTROL = 5'h10;
  localparam logic [4:0] ADDR_DETAIL_STATUS = 5'h11;

  // Control word fields
  localparam int CTL_LOOPBACK = 14;
  localparam int CTL_SPEED = 13;
  localparam int CTL_AN_ENABLE = 12;
  localparam int CTL_LOW_POWER = 11;
  localparam int CTL_ISOLATE = 10;
  localparam int CTL_AN_RESTART = 9;
  localparam int CTL_DUPLEX = 8;
  localparam int CTL_COL_TEST = 7;

  // Status word fields
  localparam int ST_T4 = 15;
  localparam int ST_CW_HI = 14;
  localparam int ST_CW_LO = 6;
  localparam int ST_PREAMBLE_SUPP = 6;
  localparam int ST_AN_COMPLETE = 5;
  localparam int ST_REMOTE_FAULT = 4;
  localparam int ST_AN_ABILITY = 3;
  localparam int ST_LINK = 2;
  localparam int ST_JABBER = 1;
  localparam int ST_EXT_CAP = 0;
  localparam logic [8:0] ST_CW_RESET = 9'h1E0;

  localparam int EXT_OVERRIDE_WE = 15;
  localparam int DET_DUPLEX = 14;
  localparam int DET_REMOTE_FAULT = 1;
  localparam int DET_LINK = 0;

  // Control reset values
  localparam logic CTL_LOOPBACK_RST = 1'b0;
  localparam logic CTL_SPEED_RST = 1'b1;
  localparam logic CTL_AN_ENABLE_RST = 1'b1;
  localparam logic CTL_DUPLEX_RST = 1'b0;
  localparam logic CTL_COL_TEST_RST = 1'b0;

  typedef enum logic [4:0] {
    MS_IDLE = 5'h01,
    MS_HDR = 5'h02,
    MS_TA = 5'h04,
    MS_READ = 5'h08,
    MS_WRITE = 5'h10
  } pcsr_mstate_type;

endpackage

/* File: hdl/pcsr_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes synchronous active-low reset on the destination clock.
`timescale 1ns/1ps
module pcsr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,            // Destination clock
  input wire logic resetn,              // Synchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // Levels from another domain
  output logic [WIDTH-1:0] sync_out     // Levels safe to read
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } pcsr_sync_state_type;

  pcsr_sync_state_type r;
  pcsr_sync_state_type next_r;

  initial begin
    if (WIDTH < 1) begin
      $error("pcsr_sync: WIDTH must be at least 1");
    end
  end

  always_comb begin
    next_r.meta = async_in;
    next_r.stable = r.meta;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.stable;

endmodule

/* File: hdl/pcsr_regs.sv */
// Control and status register bank of a 10/100 PHY, reached over the serial management link.
// Assumes link clock and data, strap, duplex pin, transmit enable and address pins are asynchronous;
// negotiation, link and fault inputs come from core logic on core_clk.
`timescale 1ns/1ps

module pcsr_regs (
  input wire logic core_clk,        // 40 MHz core clock
  input wire logic resetn,          // Synchronous reset, active low
  input wire logic mgmt_clk,        // Management link clock pin
  input wire logic mgmt_data_in,    // Management data pin, input side
  output logic mgmt_data_out,       // Management data pin, output side
  output logic mgmt_data_oe,        // Management data pin, output enable
  input wire logic [4:0] phy_addr,  // Address strap pins
  input wire logic config_mode_strap, // Low hardware mode, high software mode
  input wire logic duplex_select_pin, // Hardware-mode duplex select, high full
  input wire logic txen,            // Transmit enable from the MAC
  input wire logic col_detect,      // Line collision from the datapath
  input wire logic an_started,      // Pulse: negotiation has begun
  input wire logic an_complete,     // Level: negotiation has completed
  input wire logic an_duplex_full,  // Level: negotiated duplex is full
  input wire logic remote_fault,    // Level: partner signals fault
  input wire logic link_ok,         // Level: link monitor sees valid link
  output logic col,                 // Collision to the MAC
  output logic duplex_full,         // Effective duplex, high full
  output logic an_restart,          // Level: negotiation restart request
  output logic an_enable,           // Negotiation enable control
  output logic loopback_en,         // Loopback control
  output logic speed_100,           // Data rate control
  output logic low_power,           // Low-power control
  output logic isolate              // Isolate control
);

  typedef struct packed {
    pcsr_pkg::pcsr_mstate_type st;
    logic [4:0] cnt;
    logic [5:0] ones;
    logic [12:0] hdr;
    logic [15:0] shreg;
    logic mdo;
    logic mdoe;
    logic mdc_prev;
    logic loopback;
    logic speed;
    logic an_en;
    logic low_pwr;
    logic iso;
    logic restart;
    logic duplex;
    logic col_test;
    logic [8:0] cw_bits;
    logic override_we;
    logic an_done_lh;
    logic rfault_lh;
    logic link_ll;
    logic col;
    logic dpx_full;
  } pcsr_state_type;

  pcsr_state_type r;
  pcsr_state_type next_r;

  logic [9:0] sync_in;
  logic [9:0] sync_out;
  logic mdc_s;
  logic mdio_s;
  logic strap_s;
  logic dpx_pin_s;
  logic txen_s;
  logic [4:0] addr_s;

  initial begin
    if (pcsr_pkg::COL_PATH_CYCLES > pcsr_pkg::COL_ASSERT_CYCLES) begin
      $error("pcsr_regs: collision path slower than the assert bound");
    end
  end

  assign sync_in = {phy_addr, txen, duplex_select_pin, config_mode_strap, mgmt_data_in, mgmt_clk};

  pcsr_sync #(.WIDTH(10)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(sync_in),
    .sync_out(sync_out)
  );

  assign mdc_s = sync_out[0];
  assign mdio_s = sync_out[1];
  assign strap_s = sync_out[2];
  assign dpx_pin_s = sync_out[3];
  assign txen_s = sync_out[4];
  assign addr_s = sync_out[9:5];

  always_comb begin
    logic rise;
    logic [1:0] op;
    logic [4:0] ad;
    logic [4:0] ra;
    logic [15:0] rdata;
    logic [15:0] wdata;
    logic an_live;
    logic clr_rf;
    logic clr_st;
    rise = 1'b0;
    op = '0;
    ad = '0;
    ra = '0;
    rdata = '0;
    wdata = '0;
    an_live = 1'b0;
    clr_rf = 1'b0;
    clr_st = 1'b0;
    next_r = r;
    next_r.mdc_prev = mdc_s;
    rise = mdc_s & ~r.mdc_prev;
    op = r.hdr[11:10];
    // Address field as it stands one bit before the header completes
    ad = r.hdr[8:4];
    ra = r.hdr[4:0];
    wdata = {r.shreg[14:0], mdio_s};

    // Register read image; capability and constant bits included
    rdata = '0;
    unique case (ra)
      pcsr_pkg::ADDR_CONTROL: begin
        rdata[pcsr_pkg::CTL_LOOPBACK] = r.loopback;
        rdata[pcsr_pkg::CTL_SPEED] = r.speed;
        rdata[pcsr_pkg::CTL_AN_ENABLE] = r.an_en;
        rdata[pcsr_pkg::CTL_LOW_POWER] = r.low_pwr;
        rdata[pcsr_pkg::CTL_ISOLATE] = r.iso;
        rdata[pcsr_pkg::CTL_AN_RESTART] = r.restart;
        rdata[pcsr_pkg::CTL_DUPLEX] = r.duplex;
        rdata[pcsr_pkg::CTL_COL_TEST] = r.col_test; // Bits 6..0 stay zero
      end
      pcsr_pkg::ADDR_STATUS: begin
        rdata[pcsr_pkg::ST_T4] = 1'b0;
        rdata[pcsr_pkg::ST_CW_HI:pcsr_pkg::ST_CW_LO] = r.cw_bits;
        rdata[pcsr_pkg::ST_AN_COMPLETE] = r.an_done_lh;
        rdata[pcsr_pkg::ST_REMOTE_FAULT] = r.rfault_lh;
        rdata[pcsr_pkg::ST_AN_ABILITY] = 1'b1;
        rdata[pcsr_pkg::ST_LINK] = r.link_ll;
        rdata[pcsr_pkg::ST_EXT_CAP] = 1'b1;
        clr_rf = 1'b1;
        clr_st = 1'b1;
      end
      pcsr_pkg::ADDR_EXT_CONTROL: begin
        rdata[pcsr_pkg::EXT_OVERRIDE_WE] = r.override_we;
      end
      pcsr_pkg::ADDR_DETAIL_STATUS: begin
        rdata[pcsr_pkg::DET_DUPLEX] = r.dpx_full & link_ok; // Duplex of an active link
        rdata[pcsr_pkg::DET_REMOTE_FAULT] = r.rfault_lh;
        rdata[pcsr_pkg::DET_LINK] = r.link_ll;
        clr_rf = 1'b1;
      end
      default: begin
        rdata = '0;
      end
    endcase

    // Management frame engine, acting on sampled link clock rising edges
    unique case (r.st)
      pcsr_pkg::MS_IDLE: begin
        if (rise) begin
          if (mdio_s) begin
            if (r.ones != pcsr_pkg::PREAMBLE_ONES) begin
              next_r.ones = r.ones + 6'h01;
            end
          end else begin
            next_r.ones = '0;
            if (r.ones == pcsr_pkg::PREAMBLE_ONES || r.cw_bits[pcsr_pkg::ST_PREAMBLE_SUPP - pcsr_pkg::ST_CW_LO]) begin
              next_r.st = pcsr_pkg::MS_HDR;
              next_r.cnt = '0;
            end
          end
        end
      end
      pcsr_pkg::MS_HDR: begin
        if (rise) begin
          next_r.hdr = {r.hdr[11:0], mdio_s};
          next_r.cnt = r.cnt + 5'h01;
          if (r.cnt == pcsr_pkg::HDR_BITS - 5'h01) begin
            next_r.cnt = '0;
            if (r.hdr[11] && ad == addr_s &&
                ({r.hdr[10:9]} == pcsr_pkg::OP_READ || {r.hdr[10:9]} == pcsr_pkg::OP_WRITE)) begin
              next_r.st = pcsr_pkg::MS_TA;
            end else begin
              next_r.st = pcsr_pkg::MS_IDLE;
            end
          end
        end
      end
      pcsr_pkg::MS_TA: begin
        if (rise) begin
          next_r.cnt = r.cnt + 5'h01;
          if (op == pcsr_pkg::OP_READ && r.cnt == '0) begin
            next_r.mdoe = 1'b1;
            next_r.mdo = 1'b0;
          end
          if (r.cnt == pcsr_pkg::TA_BITS - 5'h01) begin
            next_r.cnt = '0;
            if (op == pcsr_pkg::OP_READ) begin
              next_r.st = pcsr_pkg::MS_READ;
              next_r.mdo = rdata[15];
              next_r.shreg = {rdata[14:0], 1'b0};
              // Clear-on-read reloads from the live condition; a live set wins
              if (clr_rf) begin
                next_r.rfault_lh = remote_fault;
              end
              if (clr_st) begin
                next_r.an_done_lh = an_complete & r.an_en;
              end
              if (clr_rf) begin
                next_r.link_ll = link_ok;
              end
            end else begin
              next_r.st = pcsr_pkg::MS_WRITE;
            end
          end
        end
      end
      pcsr_pkg::MS_READ: begin
        if (rise) begin
          next_r.cnt = r.cnt + 5'h01;
          next_r.mdo = r.shreg[15];
          next_r.shreg = {r.shreg[14:0], 1'b0};
          if (r.cnt == pcsr_pkg::DATA_BITS - 5'h01) begin
            next_r.mdoe = 1'b0;
            next_r.mdo = 1'b0;
            next_r.st = pcsr_pkg::MS_IDLE;
          end
        end
      end
      pcsr_pkg::MS_WRITE: begin
        if (rise) begin
          next_r.cnt = r.cnt + 5'h01;
          next_r.shreg = wdata;
          if (r.cnt == pcsr_pkg::DATA_BITS - 5'h01) begin
            next_r.st = pcsr_pkg::MS_IDLE;
            if (ra == pcsr_pkg::ADDR_CONTROL) begin
              next_r.loopback = wdata[pcsr_pkg::CTL_LOOPBACK];
              next_r.speed = wdata[pcsr_pkg::CTL_SPEED];
              next_r.an_en = wdata[pcsr_pkg::CTL_AN_ENABLE];
              next_r.low_pwr = wdata[pcsr_pkg::CTL_LOW_POWER];
              next_r.iso = wdata[pcsr_pkg::CTL_ISOLATE];
              next_r.duplex = wdata[pcsr_pkg::CTL_DUPLEX];
              next_r.col_test = wdata[pcsr_pkg::CTL_COL_TEST];
              if (wdata[pcsr_pkg::CTL_AN_RESTART] && wdata[pcsr_pkg::CTL_AN_ENABLE]) begin
                next_r.restart = 1'b1;
              end
            end
            if (ra == pcsr_pkg::ADDR_STATUS && r.override_we) begin
              next_r.cw_bits = wdata[pcsr_pkg::ST_CW_HI:pcsr_pkg::ST_CW_LO];
            end
            if (ra == pcsr_pkg::ADDR_EXT_CONTROL) begin
              next_r.override_we = wdata[pcsr_pkg::EXT_OVERRIDE_WE];
            end
          end
        end
      end
      default: begin
        next_r.st = pcsr_pkg::MS_IDLE;
        next_r.mdoe = 1'b0;
      end
    endcase

    // Restart self-clears once negotiation begins, and never stands while disabled
    if (an_started || !next_r.an_en) begin
      next_r.restart = 1'b0;
    end

    // Latching status; a clearing read above has already reloaded the live value
    an_live = an_complete & r.an_en;
    next_r.an_done_lh = next_r.an_done_lh | an_live;
    next_r.rfault_lh = next_r.rfault_lh | remote_fault;
    next_r.link_ll = next_r.link_ll & link_ok;

    // Effective duplex selection
    if (r.loopback) begin
      next_r.dpx_full = 1'b1;
    end else if (!strap_s) begin
      next_r.dpx_full = dpx_pin_s;
    end else if (r.an_en) begin
      next_r.dpx_full = an_duplex_full;
    end else begin
      next_r.dpx_full = r.duplex;
    end

    // Collision: test mode follows transmit enable even in loopback
    if (r.col_test) begin
      next_r.col = txen_s;
    end else begin
      next_r.col = col_detect & ~r.loopback;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      r <= '0;
      r.st <= pcsr_pkg::MS_IDLE;
      r.loopback <= pcsr_pkg::CTL_LOOPBACK_RST;
      r.speed <= pcsr_pkg::CTL_SPEED_RST;
      r.an_en <= pcsr_pkg::CTL_AN_ENABLE_RST;
      r.duplex <= pcsr_pkg::CTL_DUPLEX_RST;
      r.col_test <= pcsr_pkg::CTL_COL_TEST_RST;
      r.cw_bits <= pcsr_pkg::ST_CW_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign mgmt_data_out = r.mdo;
  assign mgmt_data_oe = r.mdoe;
  assign col = r.col;
  assign duplex_full = r.dpx_full;
  assign an_restart = r.restart;
  assign an_enable = r.an_en;
  assign loopback_en = r.loopback;
  assign speed_100 = r.speed;
  assign low_power = r.low_pwr;
  assign isolate = r.iso;

endmodule

/* File: test/pcsr_properties.sv */
// Concurrent checks on the ports of the PHY control/status register bank.
// Assumes one core clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module pcsr_properties (
  input wire logic core_clk, // Core clock
  input wire logic resetn, // Reset, active low
  input wire logic config_mode_strap, // Mode strap
  input wire logic duplex_select_pin, // Hardware duplex pin
  input wire logic txen, // Transmit enable
  input wire logic col_detect, // Line collision
  input wire logic an_started, // Negotiation began
  input wire logic an_duplex_full, // Negotiated duplex
  input wire logic col, // Collision out
  input wire logic duplex_full, // Effective duplex
  input wire logic an_restart, // Restart request
  input wire logic an_enable, // Negotiation enable
  input wire logic loopback_en // Loopback control
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_hw_steady;
    (!config_mode_strap && !loopback_en && $stable(duplex_select_pin))[*5];
  endsequence
  sequence s_sw_an_steady;
    (config_mode_strap && an_enable && !loopback_en && $stable(an_duplex_full))[*5];
  endsequence
  sequence s_tx_drop;
    $fell(txen) ##1 (!txen && !col_detect)[*3];
  endsequence

  property p_restart_off;
    (!an_enable)[*2] |-> !an_restart;
  endproperty
  a_restart_off: assert property (p_restart_off) else $error("restart set while negotiation off");

  property p_restart_clear;
    an_restart && an_started |=> !an_restart;
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart not cleared");

  property p_hw_duplex;
    s_hw_steady |-> duplex_full == duplex_select_pin;
  endproperty
  a_hw_duplex: assert property (p_hw_duplex) else $error("hardware duplex not from pin");

  property p_sw_an_duplex;
    s_sw_an_steady |-> duplex_full == an_duplex_full;
  endproperty
  a_sw_an_duplex: assert property (p_sw_an_duplex) else $error("duplex not from negotiation");

  property p_loop_duplex;
    loopback_en[*2] |-> duplex_full;
  endproperty
  a_loop_duplex: assert property (p_loop_duplex) else $error("duplex not fixed in loopback");

  property p_col_cause;
    $rose(col) |-> $past(col_detect) || $past(txen, 3);
  endproperty
  a_col_cause: assert property (p_col_cause) else $error("collision without cause");

  property p_col_release;
    s_tx_drop |-> !col;
  endproperty
  a_col_release: assert property (p_col_release) else $error("collision held after transmit");

  property p_col_loop;
    (loopback_en && !txen)[*4] |-> !col;
  endproperty
  a_col_loop: assert property (p_col_loop) else $error("line collision seen in loopback");
endmodule

bind pcsr_regs pcsr_properties i_pcsr_properties (.core_clk, .resetn, .config_mode_strap, .duplex_select_pin,
  .txen, .col_detect, .an_started, .an_duplex_full, .col, .duplex_full, .an_restart, .an_enable, .loopback_en);

/* File: test/pcsr_mgmt_model.sv */
// Station manager model: sends management frames and reads answers.
// Assumes a pull-up on the data line; the link clock stands low between frames.
`timescale 1ns/1ps
module pcsr_mgmt_model (
  output logic mgmt_clk, // Link clock, 200 ns period
  output logic mgmt_data_in, // Resolved data line
  input wire logic mgmt_data_out, // Device data
  input wire logic mgmt_data_oe // Device drive enable
);
  logic drv_en = 1'b0;
  logic drv_val = 1'b1;
  // Preamble length; zero sends frames without preamble
  int pre_len = 32;

  initial mgmt_clk = 1'b0;
  // Released line floats to the pull-up level
  assign mgmt_data_in = mgmt_data_oe ? mgmt_data_out : (drv_en ? drv_val : 1'b1);

  task automatic tick(input logic b, output logic s);
    drv_val = b;
    #100;
    mgmt_clk = 1'b1;
    s = mgmt_data_in;
    #100;
    mgmt_clk = 1'b0;
  endtask

  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] f;
    logic s;
    f = {2'b01, op, pa, ra, 2'b10, wd};
    drv_en = 1'b1;
    for (int i = 0; i < pre_len; i++) tick(1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      // Line handed to the device before turnaround on reads
      if (i == 17 && op == pcsr_pkg::OP_READ) drv_en = 1'b0;
      tick(f[i], s);
      if (i < 16) rd[i] = s;
    end
    if (op != pcsr_pkg::OP_READ) drv_en = 1'b0;
  endtask
endmodule

/* File: test/tb_phy_ctrl_status_regs.sv */
// Self-checking bench for the PHY control/status register bank.
// Assumes the station manager model carries all register traffic.
`timescale 1ns/1ps
module tb_phy_ctrl_status_regs;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic mgmt_clk, mgmt_data_in, mgmt_data_out, mgmt_data_oe;
  logic [4:0] phy_addr = 5'h05;
  logic config_mode_strap = 1'b1;
  logic duplex_select_pin = 1'b0;
  logic txen = 1'b0;
  logic col_detect = 1'b0;
  logic an_started = 1'b0;
  logic an_complete = 1'b0;
  logic an_duplex_full = 1'b0;
  logic remote_fault = 1'b0;
  logic link_ok = 1'b1;
  logic col, duplex_full, an_restart, an_enable, loopback_en, speed_100, low_power, isolate;
  int bad_count = 0;
  int checks_done = 0;

  pcsr_regs i_pcsr_regs (.core_clk, .resetn, .mgmt_clk, .mgmt_data_in, .mgmt_data_out, .mgmt_data_oe,
    .phy_addr, .config_mode_strap, .duplex_select_pin, .txen, .col_detect, .an_started, .an_complete,
    .an_duplex_full, .remote_fault, .link_ok, .col, .duplex_full, .an_restart, .an_enable, .loopback_en,
    .speed_100, .low_power, .isolate);
  pcsr_mgmt_model i_pcsr_mgmt_model (.mgmt_clk, .mgmt_data_in, .mgmt_data_out, .mgmt_data_oe);

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ends off the active edge so outputs are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic rdc(input string what, input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] d;
    i_pcsr_mgmt_model.xfer(pcsr_pkg::OP_READ, phy_addr, ra, 16'h0000, d);
    check(what, d, exp);
  endtask

  // Reserved bits are always written with their defaults
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    i_pcsr_mgmt_model.xfer(pcsr_pkg::OP_WRITE, phy_addr, ra, wd, d);
    cyc(4);
  endtask

  task automatic wait_col(input logic v, input int limit);
    int n;
    n = 0;
    while (col !== v && n < limit) begin
      @(negedge core_clk);
      n++;
    end
    check("col", 16'(col), 16'(v));
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    finish_test();
  end

  initial begin
    cyc(6);
    @(posedge core_clk) resetn <= 1'b1;
    cyc(4);
    check("an_enable", 16'(an_enable), 16'h0001);
    check("ctl pins reset", 16'({speed_100, low_power, isolate, loopback_en}), 16'h0008);
    rdc("ctrl reset", pcsr_pkg::ADDR_CONTROL, 16'h3000);
    rdc("status reset", pcsr_pkg::ADDR_STATUS, 16'h7809);
    rdc("status reread", pcsr_pkg::ADDR_STATUS, 16'h780D);
    @(posedge core_clk) link_ok <= 1'b0;
    cyc(3);
    @(posedge core_clk) link_ok <= 1'b1;
    cyc(3);
    rdc("link drop", pcsr_pkg::ADDR_STATUS, 16'h7809);
    rdc("link back", pcsr_pkg::ADDR_STATUS, 16'h780D);
    @(posedge core_clk) remote_fault <= 1'b1;
    cyc(3);
    @(posedge core_clk) remote_fault <= 1'b0;
    cyc(3);
    rdc("detail fault", pcsr_pkg::ADDR_DETAIL_STATUS, 16'h0003);
    rdc("fault cleared", pcsr_pkg::ADDR_STATUS, 16'h780D);
    @(posedge core_clk) an_complete <= 1'b1;
    cyc(3);
    rdc("an done", pcsr_pkg::ADDR_STATUS, 16'h782D);
    @(posedge core_clk) an_complete <= 1'b0;
    cyc(3);
    rdc("an latched", pcsr_pkg::ADDR_STATUS, 16'h782D);
    rdc("an live", pcsr_pkg::ADDR_STATUS, 16'h780D);
    wr(pcsr_pkg::ADDR_STATUS, 16'h0000);
    rdc("cw locked", pcsr_pkg::ADDR_STATUS, 16'h780D);
    wr(pcsr_pkg::ADDR_EXT_CONTROL, 16'h8000);
    wr(pcsr_pkg::ADDR_STATUS, 16'h0000);
    rdc("cw open", pcsr_pkg::ADDR_STATUS, 16'h000D);
    wr(pcsr_pkg::ADDR_STATUS, 16'h7840);
    i_pcsr_mgmt_model.pre_len = 0;
    rdc("no preamble", pcsr_pkg::ADDR_STATUS, 16'h784D);
    wr(pcsr_pkg::ADDR_STATUS, 16'h7800);
    i_pcsr_mgmt_model.pre_len = 32;
    wr(pcsr_pkg::ADDR_EXT_CONTROL, 16'h0000);
    wr(pcsr_pkg::ADDR_CONTROL, 16'h6C00);
    check("ctl pins set", 16'({speed_100, low_power, isolate, loopback_en}), 16'h000F);
    rdc("ctrl pins", pcsr_pkg::ADDR_CONTROL, 16'h6C00);
    wr(pcsr_pkg::ADDR_CONTROL, 16'h2200);
    check("restart off", 16'(an_restart), 16'h0000);
    rdc("ctrl no restart", pcsr_pkg::ADDR_CONTROL, 16'h2000);
    wr(pcsr_pkg::ADDR_CONTROL, 16'h2100);
    check("sw full", 16'(duplex_full), 16'h0001);
    wr(pcsr_pkg::ADDR_CONTROL, 16'h2000);
    check("sw half", 16'(duplex_full), 16'h0000);
    wr(pcsr_pkg::ADDR_CONTROL, 16'h3200);
    check("restart on", 16'(an_restart), 16'h0001);
    @(posedge core_clk) an_started <= 1'b1;
    @(posedge core_clk) an_started <= 1'b0;
    cyc(2);
    check("restart clear", 16'(an_restart), 16'h0000);
    @(posedge core_clk) an_duplex_full <= 1'b1;
    cyc(4);
    check("an duplex", 16'(duplex_full), 16'h0001);
    wr(pcsr_pkg::ADDR_CONTROL, 16'h3100);
    @(posedge core_clk) config_mode_strap <= 1'b0;
    cyc(5);
    check("hw half", 16'(duplex_full), 16'h0000);
    @(posedge core_clk) duplex_select_pin <= 1'b1;
    cyc(5);
    check("hw full", 16'(duplex_full), 16'h0001);
    rdc("detail duplex", pcsr_pkg::ADDR_DETAIL_STATUS, 16'h4001);
    @(posedge core_clk) config_mode_strap <= 1'b1;
    wr(pcsr_pkg::ADDR_CONTROL, 16'h6000);
    @(posedge core_clk) col_detect <= 1'b1;
    cyc(4);
    check("loop duplex", 16'(duplex_full), 16'h0001);
    check("loop col", 16'(col), 16'h0000);
    @(posedge core_clk) col_detect <= 1'b0;
    wr(pcsr_pkg::ADDR_CONTROL, 16'h6080);
    @(posedge core_clk) txen <= 1'b1;
    wait_col(1'b1, pcsr_pkg::COL_ASSERT_CYCLES);
    @(posedge core_clk) txen <= 1'b0;
    wait_col(1'b0, pcsr_pkg::COL_PATH_CYCLES + 1);
    wr(pcsr_pkg::ADDR_CONTROL, 16'h2000);
    @(posedge core_clk) txen <= 1'b1;
    cyc(8);
    check("test off col", 16'(col), 16'h0000);
    @(posedge core_clk) txen <= 1'b0;
    cyc(4);
    finish_test();
  end
endmodule
